// [verilog/umbc_ctrl.sv]
// umbc_ctrl: serial control, power-control serial bits, baud control and baud generator.
// assumes the serial shifter reports frame events as one-cycle pulses on CORE_CLK.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module umbc_ctrl
  import umbc_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register port
  input wire umbc_bus_t BUS,
  output var logic [7:0] RDATA,
  // shifter events
  input wire umbc_evt_t EVT,
  input wire logic DOUBLE_SPEED_CLOCK,
  input wire logic TIMER_BAUD_TICK,
  // shifter controls
  output var logic [1:0] MODE,
  output var logic MULTIPROC_ENABLE,
  output var logic RX_ENABLE,
  output var logic TX_NINTH_BIT,
  output var logic TX_DONE_FLAG,
  output var logic RX_DONE_FLAG,
  output var logic TX_BAUD_TICK,
  output var logic RX_BAUD_TICK,
  output var logic MODE0_TICK,
  output var logic BAUD_DOUBLER
);

  umbc_state_t q;
  umbc_state_t next_q;

  function automatic logic wr_hit(input umbc_bus_t b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] mode;
    logic fire;
    logic [3:0] pre_lim;
    logic [7:0] post_lim;
    logic [7:0] div;
    mode = {q.sm_hi, q.sctl_lo[UMBC_B_SM_LO]};
    fire = 1'b0;
    pre_lim = q.baud[UMBC_B_FAST] ? 4'h1 : UMBC_SLOW_PRE;
    post_lim = UMBC_GEN_POST >> (2'(q.pwr[UMBC_B_DBL]) + 2'(DOUBLE_SPEED_CLOCK));
    div = {4'h0, UMBC_M0_DIV} >> DOUBLE_SPEED_CLOCK;
    next_q = q;
    next_q.gen_tick = 1'b0;
    // register writes
    if (wr_hit(BUS, UMBC_ADDR_SCTL)) begin
      next_q.sctl_lo = BUS.wdata[6:0];
      if (q.pwr[UMBC_B_B7SEL]) begin
        if (!BUS.wdata[UMBC_B_B7]) begin
          next_q.fe = 1'b0;
        end
      end else begin
        next_q.sm_hi = BUS.wdata[UMBC_B_B7];
      end
    end
    if (wr_hit(BUS, UMBC_ADDR_PWR)) begin
      next_q.pwr = BUS.wdata;
    end
    if (wr_hit(BUS, UMBC_ADDR_BAUD)) begin
      next_q.baud = BUS.wdata[4:0];
    end
    if (wr_hit(BUS, UMBC_ADDR_BRL)) begin
      next_q.baud_reload_value = BUS.wdata;
    end
    // hardware events, after writes so a set wins
    if (EVT.rx_stop_done && !EVT.rx_stop_valid && q.sctl_lo[UMBC_B_REN]) begin
      next_q.fe = 1'b1;
    end
    if ((mode == UMBC_MODE_SHIFT) ? EVT.tx_frame_start : EVT.tx_stop_start) begin
      next_q.sctl_lo[UMBC_B_TI] = 1'b1;
    end
    if (EVT.rx_stop_done && q.sctl_lo[UMBC_B_REN]) begin
      if (mode == UMBC_MODE_SHIFT) begin
        next_q.sctl_lo[UMBC_B_RI] = 1'b1;
      end else if (mode == UMBC_MODE_8VAR) begin
        if (!q.sctl_lo[UMBC_B_MPE]) begin
          next_q.sctl_lo[UMBC_B_RB8] = EVT.rx_stop_bit;
          next_q.sctl_lo[UMBC_B_RI] = 1'b1;
        end else if (EVT.rx_stop_valid) begin
          next_q.sctl_lo[UMBC_B_RI] = 1'b1;
        end
      end else begin
        next_q.sctl_lo[UMBC_B_RB8] = EVT.rx_ninth;
        if (!q.sctl_lo[UMBC_B_MPE] || EVT.rx_ninth) begin
          next_q.sctl_lo[UMBC_B_RI] = 1'b1;
        end
      end
    end
    // internal generator: pre-scale, reload counter, post divide
    if (q.baud[UMBC_B_RUN]) begin
      if (q.pre_cnt >= pre_lim - 4'h1) begin
        next_q.pre_cnt = 4'h0;
        if (q.gen_cnt == 8'hFF) begin
          next_q.gen_cnt = q.baud_reload_value;
          fire = 1'b1;
        end else begin
          next_q.gen_cnt = q.gen_cnt + 8'h01;
        end
      end else begin
        next_q.pre_cnt = q.pre_cnt + 4'h1;
      end
      if (fire) begin
        if (q.post_cnt >= post_lim - 8'h01) begin
          next_q.post_cnt = 8'h00;
          next_q.gen_tick = 1'b1;
        end else begin
          next_q.post_cnt = q.post_cnt + 8'h01;
        end
      end
    end else begin
      next_q.pre_cnt = 4'h0;
      next_q.gen_cnt = q.baud_reload_value;
      next_q.post_cnt = 8'h00;
    end
    // mode 0 oscillator divide, halved in double-speed
    if (q.m0_cnt >= div - 8'h01) begin
      next_q.m0_cnt = 8'h00;
    end else begin
      next_q.m0_cnt = q.m0_cnt + 8'h01;
    end
    // read data, one cycle later
    next_q.rdata = 8'h00;
    if (BUS.rd) begin
      case (BUS.addr)
        UMBC_ADDR_SCTL: next_q.rdata = {q.pwr[UMBC_B_B7SEL] ? q.fe : q.sm_hi, q.sctl_lo};
        UMBC_ADDR_PWR: next_q.rdata = q.pwr;
        UMBC_ADDR_BAUD: next_q.rdata = {3'h0, q.baud};
        UMBC_ADDR_BRL: next_q.rdata = q.baud_reload_value;
        default: next_q.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.sctl_lo <= UMBC_SCTL_RST[6:0];
      q.sm_hi <= UMBC_SCTL_RST[UMBC_B_B7];
      q.pwr <= UMBC_PWR_RST;
      q.baud <= UMBC_BAUD_RST;
      q.baud_reload_value <= UMBC_BRL_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  logic [1:0] mode_r;
  logic [6:0] ctl_r;
  logic tx_tick_r, rx_tick_r, m0_tick_r, dbl_r;
  logic mpe_r;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= 2'h0;
      ctl_r <= 7'h00;
      tx_tick_r <= 1'b0;
      rx_tick_r <= 1'b0;
      m0_tick_r <= 1'b0;
      dbl_r <= 1'b0;
      mpe_r <= 1'b0;
    end else begin
      mode_r <= {next_q.sm_hi, next_q.sctl_lo[UMBC_B_SM_LO]};
      ctl_r <= next_q.sctl_lo;
      tx_tick_r <= q.baud[UMBC_B_TXSEL] ? q.gen_tick : TIMER_BAUD_TICK;
      rx_tick_r <= q.baud[UMBC_B_RXSEL] ? q.gen_tick : TIMER_BAUD_TICK;
      m0_tick_r <= q.baud[UMBC_B_SRC] ? q.gen_tick : (q.m0_cnt == 8'h00);
      dbl_r <= q.pwr[UMBC_B_DBL];
      mpe_r <= next_q.sctl_lo[UMBC_B_MPE]
        && ({next_q.sm_hi, next_q.sctl_lo[UMBC_B_SM_LO]} != UMBC_MODE_SHIFT);
    end
  end

  assign RDATA = q.rdata;
  assign MODE = mode_r;
  assign MULTIPROC_ENABLE = mpe_r;
  assign RX_ENABLE = ctl_r[UMBC_B_REN];
  assign TX_NINTH_BIT = ctl_r[UMBC_B_TB8];
  assign TX_DONE_FLAG = ctl_r[UMBC_B_TI];
  assign RX_DONE_FLAG = ctl_r[UMBC_B_RI];
  assign TX_BAUD_TICK = tx_tick_r;
  assign RX_BAUD_TICK = rx_tick_r;
  assign MODE0_TICK = m0_tick_r;
  assign BAUD_DOUBLER = dbl_r;

endmodule // umbc_ctrl
`default_nettype wire

// [verilog/umbc_pkg.sv]
// umbc_pkg: constants, types and register map of the serial mode and baud control block.
// assumes a single core clock domain and a plain strobe register port.
package umbc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] UMBC_ADDR_PWR = 8'h87;
  localparam logic [7:0] UMBC_ADDR_SCTL = 8'h98;
  localparam logic [7:0] UMBC_ADDR_BRL = 8'h9A;
  localparam logic [7:0] UMBC_ADDR_BAUD = 8'h9B;
  localparam logic [7:0] UMBC_PWR_RST = 8'h10;
  localparam logic [7:0] UMBC_SCTL_RST = 8'h00;
  localparam logic [4:0] UMBC_BAUD_RST = 5'h00;
  localparam logic [7:0] UMBC_BRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // bit positions
  // ----------------------------------------------------------------
  localparam int UMBC_B_B7 = 7;
  localparam int UMBC_B_SM_LO = 6;
  localparam int UMBC_B_MPE = 5;
  localparam int UMBC_B_REN = 4;
  localparam int UMBC_B_TB8 = 3;
  localparam int UMBC_B_RB8 = 2;
  localparam int UMBC_B_TI = 1;
  localparam int UMBC_B_RI = 0;
  localparam int UMBC_B_DBL = 7;
  localparam int UMBC_B_B7SEL = 6;
  localparam int UMBC_B_PWR_LO = 5;
  localparam int UMBC_B_RUN = 4;
  localparam int UMBC_B_TXSEL = 3;
  localparam int UMBC_B_RXSEL = 2;
  localparam int UMBC_B_FAST = 1;
  localparam int UMBC_B_SRC = 0;

  // ----------------------------------------------------------------
  // timing constants
  // ----------------------------------------------------------------
  localparam logic [3:0] UMBC_M0_DIV = 4'hC;
  localparam logic [3:0] UMBC_SLOW_PRE = 4'h6;
  localparam logic [7:0] UMBC_GEN_POST = 8'h40;
  localparam logic [7:0] UMBC_M2_DIV = 8'h40;

  typedef enum logic [1:0] {
    UMBC_MODE_SHIFT = 2'h0,
    UMBC_MODE_8VAR = 2'h1,
    UMBC_MODE_9FIX = 2'h2,
    UMBC_MODE_9VAR = 2'h3
  } umbc_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } umbc_bus_t;

  typedef struct packed {
    logic tx_frame_start;
    logic tx_stop_start;
    logic rx_stop_done;
    logic rx_ninth;
    logic rx_stop_bit;
    logic rx_stop_valid;
  } umbc_evt_t;

  typedef struct packed {
    logic sm_hi;
    logic fe;
    logic [6:0] sctl_lo;
    logic [7:0] pwr;
    logic [4:0] baud;
    logic [7:0] baud_reload_value;
    logic [3:0] pre_cnt;
    logic [7:0] gen_cnt;
    logic [7:0] post_cnt;
    logic gen_tick;
    logic [7:0] m0_cnt;
    logic [7:0] rdata;
  } umbc_state_t;

endpackage : umbc_pkg

// [dv/umbc_properties.sv]
// umbc_chk: port checks of the serial mode and baud control block.
// assumes a bind onto umbc_ctrl and a single core clock.
`timescale 1ns/1ps
`default_nettype none
module umbc_chk
  import umbc_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // watched ports
  input wire umbc_bus_t BUS,
  input wire umbc_evt_t EVT,
  input wire logic [1:0] MODE,
  input wire logic MULTIPROC_ENABLE,
  input wire logic RX_ENABLE,
  input wire logic TX_NINTH_BIT,
  input wire logic TX_DONE_FLAG,
  input wire logic RX_DONE_FLAG,
  input wire logic BAUD_DOUBLER
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire logic sw = BUS.wr && BUS.addr == UMBC_ADDR_SCTL;
  a_ctrl_write:
    assert property (sw |=> MODE[0] == $past(BUS.wdata[6]) && RX_ENABLE == $past(BUS.wdata[4])
      && TX_NINTH_BIT == $past(BUS.wdata[3])) else $error("control write lost");
  a_mode_hold:
    assert property (!sw |=> $stable(MODE)) else $error("mode moved");
  a_mpe_mode0:
    assert property (MODE == 2'h0 |-> !MULTIPROC_ENABLE) else $error("multiproc in mode 0");
  a_tx_done_set:
    assert property ((MODE == 2'h0 ? EVT.tx_frame_start : EVT.tx_stop_start) |=> TX_DONE_FLAG)
      else $error("tx done not set");
  a_rx_done_m0:
    assert property (EVT.rx_stop_done && RX_ENABLE && MODE == 2'h0 |=> RX_DONE_FLAG)
      else $error("rx done not set");
  a_rx_done_m23:
    assert property (EVT.rx_stop_done && RX_ENABLE && MODE[1]
      && (!MULTIPROC_ENABLE || EVT.rx_ninth) |=> RX_DONE_FLAG) else $error("rx done missing");
  a_rx_off_hold:
    assert property (EVT.rx_stop_done && !RX_ENABLE && !sw |=> $stable(RX_DONE_FLAG))
      else $error("rx done moved");
  a_dbl_write:
    assert property (BUS.wr && BUS.addr == UMBC_ADDR_PWR |-> ##2 BAUD_DOUBLER == $past(BUS.wdata[7], 2))
      else $error("doubler write lost");
endmodule // umbc_chk
`default_nettype wire

// [dv/umbc_far.sv]
// umbc_far: remote side of the link, seen as shifter frame events.
// assumes calls start just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module umbc_far
  import umbc_pkg::*;
(
  // clock and events
  input wire logic clk,
  output var umbc_evt_t evt
);
  initial evt = '0;
  // one-cycle pulse, stale levels turned over
  task automatic send(input umbc_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= {3'h0, ~e[2:0]};
    #1;
  endtask
endmodule // umbc_far
`default_nettype wire

// [dv/tb.sv]
// tb: self-checking bench of the serial mode and baud control block.
// assumes umbc_ctrl, umbc_chk and the umbc_far event model.
`timescale 1ns/1ps
`default_nettype none
module tb
  import umbc_pkg::*;
;
  localparam logic [7:0] SC = UMBC_ADDR_SCTL;
  localparam logic [7:0] PW = UMBC_ADDR_PWR;
  localparam logic [7:0] BD = UMBC_ADDR_BAUD;
  logic clk, rst_n, dsc, tmr, txt, rxt, m0t, mpe, ren, tb8, tdf, rdf, dbl;
  logic [1:0] mode;
  logic [7:0] rdata;
  umbc_bus_t bus;
  umbc_evt_t evt;
  int mismatches, checks_done;
  umbc_ctrl dut (.CORE_CLK(clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata), .EVT(evt),
    .DOUBLE_SPEED_CLOCK(dsc), .TIMER_BAUD_TICK(tmr), .MODE(mode), .MULTIPROC_ENABLE(mpe),
    .RX_ENABLE(ren), .TX_NINTH_BIT(tb8), .TX_DONE_FLAG(tdf), .RX_DONE_FLAG(rdf),
    .TX_BAUD_TICK(txt), .RX_BAUD_TICK(rxt), .MODE0_TICK(m0t), .BAUD_DOUBLER(dbl));
  umbc_far far (.clk(clk), .evt(evt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk("rdata", 16'(rdata), 16'(e));
  endtask
  function automatic logic tk(input int s);
    return s == 0 ? txt : s == 1 ? rxt : m0t;
  endfunction
  task automatic w(input int s, input int b, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (!tk(s) && c < b);
  endtask
  // tick spacing, a lost tick ends the run
  task automatic gp(input int s, input logic [15:0] e);
    int c;
    w(s, 2000, c);
    w(s, 2000, c);
    chk("tick gap", 16'(c), e);
    if (c >= 2000) finish_test();
  endtask
  task automatic t_reset();
    rd(PW, 8'h10);
    rd(SC, 8'h00);
    rd(BD, 8'h00);
    rd(8'h00, 8'h00);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(SC, {m[1:0], 6'h18});
      chk("mode", 16'(mode), 16'(m));
      chk("ren tb8", 16'({ren, tb8}), 16'h3);
      rd(SC, {m[1:0], 6'h18});
    end
  endtask
  task automatic t_flags();
    wr(SC, 8'h50);
    far.send(6'h10);
    chk("tx done", 16'(tdf), 16'h1);
    far.send(6'h0B);
    rd(SC, 8'h57);
    fork
      wr(SC, 8'h54);
      far.send(6'h10);
    join
    rd(SC, 8'h56);
  endtask
  task automatic t_frame();
    wr(PW, 8'h40);
    wr(SC, 8'h50);
    far.send(6'h08);
    rd(SC, 8'hD1);
    far.send(6'h0B);
    wr(SC, 8'hD4);
    chk("mode", 16'(mode), 16'h1);
    rd(SC, 8'hD4);
    wr(PW, 8'h00);
    rd(SC, 8'h54);
    wr(PW, 8'h40);
    wr(SC, 8'h54);
    rd(SC, 8'h54);
    wr(PW, 8'h00);
  endtask
  task automatic t_multi();
    wr(SC, 8'hF0);
    far.send(6'h0B);
    chk("rx done", 16'(rdf), 16'h0);
    far.send(6'h0F);
    rd(SC, 8'hF5);
    wr(SC, 8'hC0);
    far.send(6'h0F);
    rd(SC, 8'hC0);
    wr(SC, 8'h30);
    chk("mpe", 16'(mpe), 16'h0);
    wr(SC, 8'h10);
    far.send(6'h29);
    rd(SC, 8'h13);
  endtask
  task automatic t_baud();
    int c;
    wr(UMBC_ADDR_BRL, 8'hFC);
    wr(BD, 8'h1A);
    gp(0, 16'h100);
    w(1, 600, c);
    chk("rx ticks", 16'(c), 16'h258);
    wr(PW, 8'h80);
    gp(0, 16'h080);
    chk("doubler", 16'(dbl), 16'h1);
    wr(BD, 8'h18);
    gp(0, 16'h300);
    wr(BD, 8'h08);
    w(0, 900, c);
    chk("tx ticks", 16'(c), 16'h384);
    wr(BD, 8'h00);
    gp(2, 16'h00C);
    @(posedge clk);
    dsc <= 1'b1;
    gp(2, 16'h006);
    wr(BD, 8'h13);
    gp(2, 16'h040);
  endtask
  // one timer pulse, routed per clock selects
  task automatic t_timer(input logic [7:0] b, input logic [15:0] e);
    wr(BD, b);
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    #1;
    chk("timer tick", 16'({txt, rxt}), e);
    @(posedge clk);
    #1;
    chk("tick width", 16'({txt, rxt}), 16'h0);
  endtask
  initial begin
    bus = '0;
    dsc = 1'b0;
    tmr = 1'b0;
    rst_n = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_flags();
    t_frame();
    t_multi();
    t_baud();
    t_timer(8'h00, 16'h3);
    t_timer(8'h08, 16'h1);
    t_timer(8'h04, 16'h2);
    finish_test();
  end
endmodule // tb
bind umbc_ctrl umbc_chk chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .BUS(BUS), .EVT(EVT),
  .MODE(MODE), .MULTIPROC_ENABLE(MULTIPROC_ENABLE), .RX_ENABLE(RX_ENABLE),
  .TX_NINTH_BIT(TX_NINTH_BIT), .TX_DONE_FLAG(TX_DONE_FLAG), .RX_DONE_FLAG(RX_DONE_FLAG),
  .BAUD_DOUBLER(BAUD_DOUBLER));
`default_nettype wire
